// file: clk_ctl_pkg.sv
package clk_ctl_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int REG_W = 16;
    localparam int TRIM_W = 6;

    // byte addresses of the two registers
    localparam logic [ADDR_W-1:0] CLOCK_DIVIDER_CTL_CTL_ADDR = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] RC_TRIM_ADDR = 32'h0000_0004;
    // decode compares word address bits only
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 11;

    // clock_divider_ctl field positions
    localparam int ROI_POS = 15;
    localparam int DOZE_EN_POS = 11;
    localparam int PLL96_EN_POS = 5;
    localparam int GFX_SEL_POS = 4;
    // writable bits: 15..4; bits 3..0 read as zero
    localparam logic [REG_W-1:0] CLOCK_DIVIDER_CTL_CTL_MASK = 16'hfff0;
    localparam logic [REG_W-1:0] CLOCK_DIVIDER_CTL_CTL_RESET = 16'h0000;
    localparam logic [TRIM_W-1:0] RC_TRIM_RESET = 6'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_CTL = 2'h1;
    localparam logic [1:0] SEL_TRIM = 2'h2;

    // captured ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] sel;
    } addr_phase_t;
endpackage

// file: pll_enable_and_frc_trim.sv
// Chosen here: the placing of the registers and the AHB-Lite register port.
module pll_enable_and_frc_trim (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [clk_ctl_pkg::ADDR_W-1:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [clk_ctl_pkg::DATA_W-1:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [clk_ctl_pkg::DATA_W-1:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic PLL_CONFIG_IN,
    input wire logic INTERRUPT_IN,
    output logic PLL96_ENABLE_OUT,
    output logic GFX_CLK_SEL_OUT,
    output logic DOZE_ENABLE_OUT,
    output logic [clk_ctl_pkg::TRIM_W-1:0] RC_TRIM_CODE_OUT
);
    import clk_ctl_pkg::*;

    addr_phase_t ap_r, ap_nxt;
    logic [REG_W-1:0] ctl_r, ctl_nxt;
    logic [TRIM_W-1:0] trim_r, trim_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [2:0] cfg_sync_r;
    logic ovr_r, ovr_nxt;
    logic pll_out_r, gfx_out_r, doze_out_r;
    logic [TRIM_W-1:0] trim_out_r;
    logic wr_ctl, wr_trim, take;
    logic [1:0] sel_dec;

    // address decode; hsize is not checked, only word transfers are issued
    always_comb begin
        take = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ);
        if (HADDR_IN[ADDR_MSB:ADDR_LSB] == CLOCK_DIVIDER_CTL_CTL_ADDR[ADDR_MSB:ADDR_LSB]) begin
            sel_dec = SEL_CTL;
        end else if (HADDR_IN[ADDR_MSB:ADDR_LSB] == RC_TRIM_ADDR[ADDR_MSB:ADDR_LSB]) begin
            sel_dec = SEL_TRIM;
        end else begin
            sel_dec = SEL_NONE; // unmapped: reads zero, writes dropped
        end
        ap_nxt.valid = take;
        ap_nxt.write = HWRITE_IN;
        ap_nxt.sel = take ? sel_dec : SEL_NONE;
        wr_ctl = ap_r.valid && ap_r.write && (ap_r.sel == SEL_CTL);
        wr_trim = ap_r.valid && ap_r.write && (ap_r.sel == SEL_TRIM);
    end

    // register next values; data-phase writes land here
    always_comb begin
        ctl_nxt = ctl_r;
        trim_nxt = trim_r;
        if (wr_ctl) begin
            ctl_nxt = HWDATA_IN[REG_W-1:0] & CLOCK_DIVIDER_CTL_CTL_MASK;
        end
        if (wr_trim) begin
            trim_nxt = HWDATA_IN[TRIM_W-1:0];
        end
        // hardware clear wins over a same-cycle software set, so doze never survives an interrupt while recovery is armed
        if (ctl_r[ROI_POS] && INTERRUPT_IN) begin
            ctl_nxt[DOZE_EN_POS] = 1'b0;
        end
    end

    // read data built from next values so a read right after a write sees it
    always_comb begin
        rdata_nxt = '0;
        if (take && !HWRITE_IN) begin
            unique case (sel_dec)
                SEL_CTL: rdata_nxt[REG_W-1:0] = ctl_nxt & CLOCK_DIVIDER_CTL_CTL_MASK;
                SEL_TRIM: rdata_nxt[TRIM_W-1:0] = trim_nxt;
                default: rdata_nxt = '0;
            endcase
        end
    end

    // config strap: three flops, a change counts once stages two and three agree
    always_comb begin
        ovr_nxt = ovr_r;
        if (cfg_sync_r[1] == cfg_sync_r[2]) begin
            ovr_nxt = cfg_sync_r[2];
        end
    end

    // bus side and control registers
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            ap_r <= '0;
            ctl_r <= CLOCK_DIVIDER_CTL_CTL_RESET;
            trim_r <= RC_TRIM_RESET;
            rdata_r <= '0;
            cfg_sync_r <= '0;
            ovr_r <= 1'b0;
        end else begin
            ap_r <= ap_nxt;
            ctl_r <= ctl_nxt;
            trim_r <= trim_nxt;
            rdata_r <= rdata_nxt;
            cfg_sync_r <= {cfg_sync_r[1:0], PLL_CONFIG_IN};
            ovr_r <= ovr_nxt;
        end
    end

    // output next values; the strap override is or-ed in after its filter
    logic pll_out_nxt, gfx_out_nxt, doze_out_nxt;
    logic [TRIM_W-1:0] trim_out_nxt;
    always_comb begin
        pll_out_nxt = ctl_r[PLL96_EN_POS] | ovr_r;
        gfx_out_nxt = ctl_r[GFX_SEL_POS];
        doze_out_nxt = ctl_r[DOZE_EN_POS];
        trim_out_nxt = trim_r;
    end

    // output flops; one cycle behind the registers
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            pll_out_r <= 1'b0;
            gfx_out_r <= 1'b0;
            doze_out_r <= 1'b0;
            trim_out_r <= RC_TRIM_RESET;
        end else begin
            pll_out_r <= pll_out_nxt;
            gfx_out_r <= gfx_out_nxt;
            doze_out_r <= doze_out_nxt;
            trim_out_r <= trim_out_nxt;
        end
    end

    // bus answer; kept as flops so the top outputs stay registered
    logic ready_nxt, resp_nxt;
    always_comb begin
        ready_nxt = 1'b1; // no wait states are ever needed
        resp_nxt = 1'b0;
    end

    // zero wait states, always OKAY
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end else begin
            HREADYOUT_OUT <= ready_nxt;
            HRESP_OUT <= resp_nxt;
        end
    end

    assign HRDATA_OUT = rdata_r;
    assign PLL96_ENABLE_OUT = pll_out_r;
    assign GFX_CLK_SEL_OUT = gfx_out_r;
    assign DOZE_ENABLE_OUT = doze_out_r;
    assign RC_TRIM_CODE_OUT = trim_out_r;

    // helper: data phase of a read
    logic rd_ctl, rd_trim;
    always_comb begin
        rd_ctl = ap_r.valid && !ap_r.write && (ap_r.sel == SEL_CTL);
        rd_trim = ap_r.valid && !ap_r.write && (ap_r.sel == SEL_TRIM);
    end

    // checks
    property p_pll_on;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (wr_ctl && HWDATA_IN[PLL96_EN_POS]) |=> ##1 PLL96_ENABLE_OUT;
    endproperty
    a_pll_on: assert property (p_pll_on) else $error("pll not enabled after write");

    property p_pll_off;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (wr_ctl && !HWDATA_IN[PLL96_EN_POS]) ##1 !ovr_r |=> !PLL96_ENABLE_OUT;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("pll not disabled after write");

    property p_override;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        ovr_r |=> PLL96_ENABLE_OUT;
    endproperty
    a_override: assert property (p_override) else $error("override did not force pll on");

    property p_gfx_sel;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        wr_ctl |=> ##1 (GFX_CLK_SEL_OUT == $past(HWDATA_IN[GFX_SEL_POS], 2));
    endproperty
    a_gfx_sel: assert property (p_gfx_sel) else $error("graphics select mismatch");

    property p_low_zero;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        rd_ctl |-> (HRDATA_OUT[3:0] == 4'h0);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("unimplemented bits not zero");

    property p_doze_clear;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ctl_r[ROI_POS] && INTERRUPT_IN) |=> ##1 !DOZE_ENABLE_OUT;
    endproperty
    a_doze_clear: assert property (p_doze_clear) else $error("doze not cleared on interrupt");

    property p_trim_apply;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        wr_trim |=> ##1 (RC_TRIM_CODE_OUT == $past(HWDATA_IN[TRIM_W-1:0], 2));
    endproperty
    a_trim_apply: assert property (p_trim_apply) else $error("trim code not applied");

    property p_trim_read;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        rd_trim |-> (HRDATA_OUT == {{(DATA_W-TRIM_W){1'b0}}, trim_r});
    endproperty
    a_trim_read: assert property (p_trim_read) else $error("trim readback mismatch");

    // register state checks
    property p_ctl_write;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (wr_ctl && !(ctl_r[ROI_POS] && INTERRUPT_IN)) |=> (ctl_r == ($past(HWDATA_IN[REG_W-1:0]) & CLOCK_DIVIDER_CTL_CTL_MASK));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write not stored");

    property p_ctl_low;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        1'b1 |-> (ctl_r[3:0] == 4'h0);
    endproperty
    a_ctl_low: assert property (p_ctl_low) else $error("unimplemented bits stored");

    property p_trim_write;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        wr_trim |=> (trim_r == $past(HWDATA_IN[TRIM_W-1:0]));
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write not stored");

    property p_ctl_read;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        rd_ctl |-> (HRDATA_OUT == {{(DATA_W-REG_W){1'b0}}, ctl_r});
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control readback mismatch");

    property p_rdata_idle;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        !(rd_ctl || rd_trim) |-> (HRDATA_OUT == '0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");

    // outputs follow the registers one edge later
    property p_pll_follow;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        1'b1 |=> (PLL96_ENABLE_OUT == $past(ctl_r[PLL96_EN_POS] | ovr_r));
    endproperty
    a_pll_follow: assert property (p_pll_follow) else $error("pll output wrong");

    property p_gfx_follow;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        1'b1 |=> (GFX_CLK_SEL_OUT == $past(ctl_r[GFX_SEL_POS]));
    endproperty
    a_gfx_follow: assert property (p_gfx_follow) else $error("graphics select wrong");

    property p_doze_follow;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        1'b1 |=> (DOZE_ENABLE_OUT == $past(ctl_r[DOZE_EN_POS]));
    endproperty
    a_doze_follow: assert property (p_doze_follow) else $error("doze output wrong");

    property p_trim_follow;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        1'b1 |=> (RC_TRIM_CODE_OUT == $past(trim_r));
    endproperty
    a_trim_follow: assert property (p_trim_follow) else $error("trim output wrong");

    property p_ovr_filter;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (cfg_sync_r[1] == cfg_sync_r[2]) |=> (ovr_r == $past(cfg_sync_r[2]));
    endproperty
    a_ovr_filter: assert property (p_ovr_filter) else $error("override filter wrong");

    // nothing but a write or an armed interrupt moves the registers
    property p_ctl_hold;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (!wr_ctl && !(ctl_r[ROI_POS] && INTERRUPT_IN)) |=> $stable(ctl_r);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control changed unasked");

    property p_trim_hold;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        !wr_trim |=> $stable(trim_r);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim changed unasked");

    c_pll_write: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        wr_ctl && HWDATA_IN[PLL96_EN_POS]);
    c_doze_clear: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        ctl_r[ROI_POS] && ctl_r[DOZE_EN_POS] && INTERRUPT_IN);
    c_override: cover property (@(posedge MCLK_IN) disable iff (RESET_IN) $rose(ovr_r));
    c_trim_read: cover property (@(posedge MCLK_IN) disable iff (RESET_IN) rd_trim);
    c_gfx_select: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        wr_ctl && HWDATA_IN[GFX_SEL_POS]);
endmodule // pll_enable_and_frc_trim

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_ctl_pkg::*;
    typedef struct {logic [31:0] a, d, r; logic [8:0] o;} row_t;
    logic clk = 1'b0, rst = 1'b1, sel = 1'b0, wr = 1'b0, cfg = 1'b0, irq = 1'b0;
    logic [1:0] trans = 2'h0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, hrdata;
    logic rdy, resp, pll, gfx, doze;
    logic [5:0] trim;
    int err_count = 0, samples_checked = 0, cycles = 0;
    // address, write data, read-back, {pll, gfx sel, doze, trim} after the write
    // cpu divider bits 7..6 stay zero in every row written
    // no usb or graphics load is modelled, so rows may turn the pll off
    row_t rows[9] = '{'{32'h0, 32'h0000_0030, 32'h30, 9'h180},
        '{32'h0, 32'hffff_002f, 32'h20, 9'h100}, '{32'h0, 32'h0000_0810, 32'h810, 9'h0c0},
        '{32'h4, 32'hffff_ffff, 32'h3f, 9'h0ff}, '{32'h4, 32'h20, 32'h20, 9'h0e0},
        '{32'h4, 32'h1f, 32'h1f, 9'h0df}, '{32'h4, 32'h01, 32'h01, 9'h0c1},
        '{32'h4, 32'h00, 32'h00, 9'h0c0}, '{32'h100, 32'hffff_ffff, 32'h0, 9'h0c0}};

    always #12.5 clk = ~clk;

    // hready is looped back, as the only slave on the bus
    pll_enable_and_frc_trim i_dut (.MCLK_IN(clk), .RESET_IN(rst), .HSEL_IN(sel),
        .HADDR_IN(addr), .HTRANS_IN(trans), .HWRITE_IN(wr), .HSIZE_IN(3'h2),
        .HWDATA_IN(wdata), .HREADY_IN(rdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy),
        .HRESP_OUT(resp), .PLL_CONFIG_IN(cfg), .INTERRUPT_IN(irq),
        .PLL96_ENABLE_OUT(pll), .GFX_CLK_SEL_OUT(gfx), .DOZE_ENABLE_OUT(doze),
        .RC_TRIM_CODE_OUT(trim));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one single transfer; entered just after a rising edge
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        sel <= 1'b1;
        trans <= HTRANS_NONSEQ;
        addr <= a;
        wr <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        trans <= 2'h0;
        wdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rdata = hrdata;
    endtask

    task rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    task report_and_stop;
        $display("counts: checked=%0d bad=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, far above the expected run of about 85 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            report_and_stop;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({pll, gfx, doze, trim, rdy, resp}, 32'h002);
        rd_chk(CLOCK_DIVIDER_CTL_CTL_ADDR, 32'h0);
        rd_chk(RC_TRIM_ADDR, 32'h0);
        $display("test reset values done");
        // each write read back at once; outputs have settled by then
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].r);
            chk({pll, gfx, doze, trim}, rows[i].o);
        end
        $display("test register table done");
        // config bit forces the pll on over a cleared enable bit
        cfg <= 1'b1;
        repeat (8) @(posedge clk);
        chk(pll, 1'b1);
        cfg <= 1'b0;
        repeat (8) @(posedge clk);
        chk(pll, 1'b0);
        $display("test pll override done");
        // interrupt with recovery armed, then without it
        bus(1'b1, CLOCK_DIVIDER_CTL_CTL_ADDR, 32'h8800);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        repeat (3) @(posedge clk);
        chk(doze, 1'b0);
        rd_chk(CLOCK_DIVIDER_CTL_CTL_ADDR, 32'h8000);
        bus(1'b1, CLOCK_DIVIDER_CTL_CTL_ADDR, 32'h0800);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        repeat (3) @(posedge clk);
        chk(doze, 1'b1);
        $display("test interrupt recovery done");
        // second reset in mid-run clears everything again
        bus(1'b1, RC_TRIM_ADDR, 32'h15);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({pll, gfx, doze, trim, rdy, resp}, 32'h002);
        rd_chk(RC_TRIM_ADDR, 32'h0);
        $display("test second reset done");
        report_and_stop;
    end
endmodule // tb_top
